// File: rtl/bit_manipulation_pkg.sv
// types shared by the bit manipulation unit
package bit_manipulation_pkg;
  typedef enum logic [3:0] {
    bit_set_op           = 4'h0,
    bit_clear_op         = 4'h1,
    bit_invert_op        = 4'h2,
    bit_test_op          = 4'h3,
    carry_and_bit_op     = 4'h4,
    carry_and_inv_bit_op = 4'h5,
    carry_or_bit_op      = 4'h6,
    carry_or_inv_bit_op  = 4'h7,
    carry_xor_bit_op     = 4'h8
  } bit_op_t;

  typedef struct packed {
    bit_op_t op;
    logic bit_from_reg;
    logic [2:0] bit_imm;
    logic [7:0] bit_reg;
  } bit_cmd_t;

  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_read   = 2'b01,
    st_modify = 2'b10,
    st_write  = 2'b11
  } rmw_state_t;
endpackage : bit_manipulation_pkg

// File: rtl/bit_manipulation_unit.sv
// single-bit operation datapath with read-modify-write sequencer
//
// What this block does
// - set selects bit to one, others kept
// - clear selects bit to zero, others kept
// - invert complements selected bit, others kept
// - test loads zero flag with inverted bit
// - bit number from immediate or register
// - carry becomes carry AND bit
// - carry becomes carry AND inverted bit
// - carry becomes carry OR bit
// - carry becomes carry OR inverted bit
// - carry becomes carry XOR bit
// - inverted carry ops take immediate only
// - set, clear, invert read-modify-write whole byte
`timescale 1ns/1ns
`include "bit_manipulation_unit_regs.svh"

module bit_manipulation_unit #(
  parameter int DATA_W = `BMU_DATA_W
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire bit_manipulation_pkg::bit_cmd_t cmd_i,
  input wire logic carry_i,
  input wire logic zero_i,
  output logic busy_o,
  output logic done_o,
  output logic rd_req_o,
  input wire logic rd_valid_i,
  input wire logic [DATA_W-1:0] rd_data_i,
  output logic wr_req_o,
  output logic [DATA_W-1:0] wr_data_o,
  input wire logic wr_ack_i,
  output logic carry_o,
  output logic zero_o,
  output logic carry_we_o,
  output logic zero_we_o,
  output logic illegal_o
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  // the bit number field and the masks assume a byte operand
  if (DATA_W != 8)
  begin : g_width_check
    $error("bit_manipulation_unit serves byte operands only");
  end

  // the bit number must reach every bit of the operand and no more
  if ((1 << `BMU_BITNO_W) != DATA_W)
  begin : g_bitno_check
    $error("bit number width does not match operand width");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] n);
    bit_mask = {{(DATA_W-1){1'b0}}, 1'b1} << n;
  endfunction : bit_mask

  function automatic logic writes_back(input bit_manipulation_pkg::bit_op_t op);
    writes_back = (op == bit_manipulation_pkg::bit_set_op) ||
                  (op == bit_manipulation_pkg::bit_clear_op) ||
                  (op == bit_manipulation_pkg::bit_invert_op);
  endfunction : writes_back

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  bit_manipulation_pkg::rmw_state_t state_q;
  bit_manipulation_pkg::rmw_state_t state_d;
  bit_manipulation_pkg::bit_cmd_t cmd_q;
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] data_d;
  logic carry_q;
  logic carry_d;
  logic zero_q;
  logic zero_d;
  logic carry_we_q;
  logic carry_we_d;
  logic zero_we_q;
  logic zero_we_d;
  logic done_q;
  logic done_d;
  logic illegal_q;
  logic illegal_d;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic inv_op = (cmd_i.op == bit_manipulation_pkg::carry_and_inv_bit_op) ||
                      (cmd_i.op == bit_manipulation_pkg::carry_or_inv_bit_op);
  // inverted carry forms have no register bit-number variant
  wire logic cmd_bad = (inv_op && cmd_i.bit_from_reg) ||
                       (cmd_i.op > bit_manipulation_pkg::carry_xor_bit_op);
  wire logic [2:0] bit_no = cmd_q.bit_from_reg ? cmd_q.bit_reg[2:0] : cmd_q.bit_imm;
  wire logic [DATA_W-1:0] mask = bit_mask(bit_no);
  wire logic sel_bit = |(rd_data_i & mask);
  // state decodes shared by the outputs and the command capture
  wire logic in_idle = (state_q == bit_manipulation_pkg::st_idle);
  wire logic in_read = (state_q == bit_manipulation_pkg::st_read);
  wire logic in_write = (state_q == bit_manipulation_pkg::st_write);
  wire logic take = clk_en_i && in_idle && start_i;

  // ---------------------------------------------------------------
  // result selection
  // ---------------------------------------------------------------
  wire logic [DATA_W-1:0] set_val;
  wire logic [DATA_W-1:0] clr_val;
  wire logic [DATA_W-1:0] inv_val;

  // one slice per operand bit; only the selected slice differs from the read byte
  for (genvar i = 0; i < DATA_W; i++)
  begin : g_bit_slice
    assign set_val[i] = mask[i] ? 1'b1 : rd_data_i[i];
    assign clr_val[i] = mask[i] ? 1'b0 : rd_data_i[i];
    assign inv_val[i] = mask[i] ? ~rd_data_i[i] : rd_data_i[i];
  end

  // ---------------------------------------------------------------
  // flag results
  // ---------------------------------------------------------------
  // carry comes from the copy taken at start, so a moving flag input cannot leak in
  wire logic c_and = carry_q & sel_bit;
  wire logic c_andn = carry_q & ~sel_bit;
  wire logic c_or = carry_q | sel_bit;
  wire logic c_orn = carry_q | ~sel_bit;
  wire logic c_xor = carry_q ^ sel_bit;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // read waits for the operand byte; modify lets the flag pulse stand before done;
  // write holds the whole byte until it is accepted
  always_comb
  begin
    state_d = state_q;
    data_d = data_q;
    carry_d = carry_q;
    zero_d = zero_q;
    carry_we_d = 1'b0;
    zero_we_d = 1'b0;
    done_d = 1'b0;
    illegal_d = 1'b0;
    case (state_q)
      bit_manipulation_pkg::st_idle:
      begin
        if (start_i)
        begin
          // a refused command still answers with done so the caller never hangs
          if (cmd_bad)
          begin
            illegal_d = 1'b1;
            done_d = 1'b1;
          end
          else
          begin
            carry_d = carry_i;
            zero_d = zero_i;
            state_d = bit_manipulation_pkg::st_read;
          end
        end
      end
      bit_manipulation_pkg::st_read:
      begin
        if (rd_valid_i)
        begin
          state_d = bit_manipulation_pkg::st_modify;
          case (cmd_q.op)
            bit_manipulation_pkg::bit_set_op: data_d = set_val;
            bit_manipulation_pkg::bit_clear_op: data_d = clr_val;
            bit_manipulation_pkg::bit_invert_op: data_d = inv_val;
            bit_manipulation_pkg::bit_test_op:
            begin
              zero_d = ~sel_bit;
              zero_we_d = 1'b1;
            end
            bit_manipulation_pkg::carry_and_bit_op:
            begin
              carry_d = c_and;
              carry_we_d = 1'b1;
            end
            bit_manipulation_pkg::carry_and_inv_bit_op:
            begin
              carry_d = c_andn;
              carry_we_d = 1'b1;
            end
            bit_manipulation_pkg::carry_or_bit_op:
            begin
              carry_d = c_or;
              carry_we_d = 1'b1;
            end
            bit_manipulation_pkg::carry_or_inv_bit_op:
            begin
              carry_d = c_orn;
              carry_we_d = 1'b1;
            end
            bit_manipulation_pkg::carry_xor_bit_op:
            begin
              carry_d = c_xor;
              carry_we_d = 1'b1;
            end
            default: data_d = data_q;
          endcase
        end
      end
      bit_manipulation_pkg::st_modify:
      begin
        // whole byte goes back only for the writing ops
        if (writes_back(cmd_q.op))
        begin
          state_d = bit_manipulation_pkg::st_write;
        end
        else
        begin
          state_d = bit_manipulation_pkg::st_idle;
          done_d = 1'b1;
        end
      end
      bit_manipulation_pkg::st_write:
      begin
        if (wr_ack_i)
        begin
          state_d = bit_manipulation_pkg::st_idle;
          done_d = 1'b1;
        end
      end
      default: state_d = bit_manipulation_pkg::st_idle;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= bit_manipulation_pkg::st_idle;
      data_q <= `BMU_DATA_RST;
      carry_q <= `BMU_CARRY_RST;
      zero_q <= `BMU_ZERO_RST;
    end
    else if (clk_en_i)
    begin
      state_q <= state_d;
      data_q <= data_d;
      carry_q <= carry_d;
      zero_q <= zero_d;
    end
  end

  // one-cycle pulses; a low enable stretches them, so callers count enabled edges
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      carry_we_q <= 1'b0;
      zero_we_q <= 1'b0;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      carry_we_q <= carry_we_d;
      zero_we_q <= zero_we_d;
      done_q <= done_d;
      illegal_q <= illegal_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cmd_q <= '0;
    end
    else if (take)
    begin
      // held for the whole sequence, so cmd_i may move once taken
      cmd_q <= cmd_i;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // requests decode straight from the state, so they drop on the accepting edge
  assign busy_o = !in_idle;
  assign rd_req_o = in_read;
  assign wr_req_o = in_write;
  assign wr_data_o = data_q;
  assign carry_o = carry_q;
  assign zero_o = zero_q;
  assign carry_we_o = carry_we_q;
  assign zero_we_o = zero_we_q;
  assign done_o = done_q;
  assign illegal_o = illegal_q;

endmodule : bit_manipulation_unit

// File: rtl/bit_manipulation_unit_regs.svh
// width and reset constants of the bit manipulation unit
`ifndef BIT_MANIPULATION_UNIT_REGS_SVH
`define BIT_MANIPULATION_UNIT_REGS_SVH
`define BMU_DATA_W 8
`define BMU_BITNO_W 3
`define BMU_CARRY_RST 1'h0
`define BMU_ZERO_RST 1'h0
`define BMU_DATA_RST 8'h00
`endif

// File: testbench/bit_manipulation_unit_sva.sv
// port assertions for the bit manipulation unit
`timescale 1ns/1ns
module bit_manipulation_unit_sva (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire bit_manipulation_pkg::bit_cmd_t cmd_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic rd_req_o,
  input wire logic wr_req_o,
  input wire logic [7:0] wr_data_o,
  input wire logic wr_ack_i,
  input wire logic carry_we_o,
  input wire logic zero_we_o,
  input wire logic illegal_o
);
  // --
  // op held for the whole command, so flags and writes can be tied to it
  // --
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [3:0] op_q;
  wire take = start_i && !busy_o && clk_en_i;
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
    if (sys_rst_i) op_q <= 4'h0;
    else if (take) op_q <= cmd_i.op;
  sequence s_take;
    take;
  endsequence
  sequence s_bad;
    take && (cmd_i.op > 4'h8 || (cmd_i.bit_from_reg && (cmd_i.op == 4'h5 || cmd_i.op == 4'h7)));
  endsequence
  chk_take_busy: assert property (s_take |=> busy_o || illegal_o)
    else $error("command not started");
  chk_bad_refused: assert property (s_bad |=> illegal_o && done_o)
    else $error("bad command not refused");
  chk_refuse_quiet: assert property (illegal_o |-> !wr_req_o && !carry_we_o && !zero_we_o)
    else $error("refused command acted");
  chk_done_idle: assert property (done_o |-> !busy_o && !rd_req_o)
    else $error("done while busy");
  chk_write_rmw: assert property (wr_req_o |-> op_q <= 4'h2 && !rd_req_o)
    else $error("write for non writing op");
  chk_zero_test: assert property (zero_we_o |-> op_q == 4'h3 && !carry_we_o)
    else $error("zero flag from wrong op");
  chk_carry_ops: assert property (carry_we_o |-> op_q >= 4'h4 && op_q <= 4'h8)
    else $error("carry flag from wrong op");
  chk_wr_hold: assert property (wr_req_o && !(wr_ack_i && clk_en_i) |=>
    wr_req_o && $stable(wr_data_o))
    else $error("write dropped before ack");
endmodule : bit_manipulation_unit_sva
bind bit_manipulation_unit bit_manipulation_unit_sva u_bit_manipulation_unit_sva (.core_clk_i,
  .sys_rst_i, .clk_en_i, .start_i, .cmd_i, .busy_o, .done_o, .rd_req_o, .wr_req_o,
  .wr_data_o, .wr_ack_i, .carry_we_o, .zero_we_o, .illegal_o);

// File: testbench/tb_bit_manipulation_unit.sv
// self-checking bench for the bit manipulation unit
`timescale 1ns/1ns
module tb_bit_manipulation_unit;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, start_i = 1'b0;
  logic carry_i = 1'b0, zero_i = 1'b0, rd_valid_i = 1'b0, wr_ack_i = 1'b0;
  logic [7:0] rd_data_i = 8'h00, cur_q = 8'h00, wr_data_o;
  bit_manipulation_pkg::bit_cmd_t cmd_i = '0;
  logic busy_o, done_o, rd_req_o, wr_req_o, carry_o, zero_o, carry_we_o, zero_we_o, illegal_o;
  logic [9:0] exp_q[$];
  int n_fail = 0, samples_checked = 0, cyc = 0, seed = 52236;
  bit stall_en = 1'b0;
  always #50 core_clk_i = ~core_clk_i;
  bit_manipulation_unit u_bit_manipulation_unit (.core_clk_i, .sys_rst_i, .clk_en_i,
    .start_i, .cmd_i, .carry_i, .zero_i, .busy_o, .done_o, .rd_req_o, .rd_valid_i,
    .rd_data_i, .wr_req_o, .wr_data_o, .wr_ack_i, .carry_o, .zero_o, .carry_we_o,
    .zero_we_o, .illegal_o);
  // --
  // memory side: random stalls; bus shows a moving pattern when not valid
  // --
  always @(negedge core_clk_i)
  begin
    rd_valid_i = stall_en ? 1'($random(seed)) : 1'b1;
    rd_data_i = rd_valid_i ? cur_q : ~rd_data_i;
    wr_ack_i = stall_en ? 1'($random(seed)) : 1'b1;
    clk_en_i = stall_en ? 2'($random(seed)) != 2'h0 : 1'b1;
  end
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      wrap_up();
    end
    if (!sys_rst_i && clk_en_i)
    begin
      if (wr_req_o && wr_ack_i) check(2'h0, wr_data_o);
      if (carry_we_o) check(2'h1, {7'h00, carry_o});
      if (zero_we_o) check(2'h2, {7'h00, zero_o});
      if (illegal_o) check(2'h3, 8'h00);
    end
  end
  task automatic check(input logic [1:0] k, input logic [7:0] v);
    logic [9:0] e;
    e = exp_q.size() != 0 ? exp_q.pop_front() : 10'h3FF;
    samples_checked++;
    if (e !== {k, v})
    begin
      n_fail++;
      $display("[ERR] result exp %h seen %h", e, {k, v});
    end
  endtask : check
  // --
  // one command: note the expectation, start it, wait for done
  // --
  task automatic run(input logic [3:0] op, input logic fr, input logic [2:0] imm,
    input logic [7:0] breg, input logic [7:0] d, input logic c);
    logic [2:0] n;
    logic b;
    n = fr ? breg[2:0] : imm;
    b = d[n];
    if (op > 4'h8 || (fr && (op == 4'h5 || op == 4'h7))) exp_q.push_back(10'h300);
    else
      case (op)
        4'h0: exp_q.push_back({2'h0, d | (8'h01 << n)});
        4'h1: exp_q.push_back({2'h0, d & ~(8'h01 << n)});
        4'h2: exp_q.push_back({2'h0, d ^ (8'h01 << n)});
        4'h3: exp_q.push_back({9'h100, ~b});
        4'h4: exp_q.push_back({9'h080, c & b});
        4'h5: exp_q.push_back({9'h080, c & ~b});
        4'h6: exp_q.push_back({9'h080, c | b});
        4'h7: exp_q.push_back({9'h080, c | ~b});
        default: exp_q.push_back({9'h080, c ^ b});
      endcase
    cur_q = d;
    cmd_i = {op, fr, imm, breg};
    carry_i = c;
    zero_i = ~c;
    start_i = 1'b1;
    do @(posedge core_clk_i); while (!(clk_en_i && !busy_o));
    @(negedge core_clk_i);
    start_i = 1'b0;
    // flags must come from the start cycle, not the live inputs
    carry_i = ~c;
    zero_i = c;
    while (done_o !== 1'b1) @(negedge core_clk_i);
  endtask : run
  initial
  begin
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i) sys_rst_i = 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      stall_en = p[0];
      for (int o = 0; o < 16; o++)
        for (int k = 0; k < 8; k++)
        begin
          automatic logic f = 1'($random(seed));
          // the unused bit number source holds the complement
          run(o[3:0], f, f ? ~k[2:0] : k[2:0], {5'($random(seed)), f ? k[2:0] : ~k[2:0]},
            8'($random(seed)), 1'($random(seed)));
        end
    end
    repeat (3) @(negedge core_clk_i);
    if (exp_q.size() != 0)
    begin
      n_fail++;
      $display("[ERR] results missing exp 0 seen %0d", exp_q.size());
    end
    wrap_up();
  end
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
endmodule : tb_bit_manipulation_unit
